// *** frame_pkg.sv ***
// Constants and types for the converter serial frame logic
package frame_pkg;
	localparam int         CMD_BITS      = 16;
	localparam int         RESULT_BITS   = 12;
	localparam int         SHIFT_BITS    = 16;
	localparam int         CNT_BITS      = 7;
	localparam int         CHAN_BITS     = 3;
	localparam int         FIFO_WIDTH    = 12;
	localparam int         FIFO_DEPTH    = 8;
	localparam logic [6:0] CMD_LAST_EDGE = 7'h10;
	localparam logic [6:0] CNT_MAX       = 7'h7F;
	localparam logic [15:0] CMD_HOLD     = 16'h0000;
	localparam logic [3:0] CMD_OP_LIGHT  = 4'h8;
	localparam logic [7:0] CMD_LIGHT     = 8'h82;
	localparam logic [7:0] CMD_DEEP      = 8'h83;
	localparam logic [7:0] CMD_AUTO      = 8'hA0;
	localparam logic [2:0] CMD_FIXED_HI  = 3'h6;
	localparam logic [2:0] CHAN_RESET    = 3'h0;
	localparam logic [15:0] GARBAGE_SEED = 16'hA5C3;
	localparam int         CONV_TIME_NS  = 2000;
	localparam int         CLK_PERIOD_NS = 50;
	localparam int         CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] CONV_COUNT    = 8'(CONV_CYCLES);

	typedef enum logic [5:0] {
		MODE_IDLE    = 6'b000001,
		MODE_LIGHT   = 6'b000010,
		MODE_DEEP    = 6'b000100,
		MODE_AUTO    = 6'b001000,
		MODE_FIXED   = 6'b010000,
		MODE_INVALID = 6'b100000
	} mode_t;
endpackage

// *** result_fifo.sv ***
// Small synchronous FIFO holding conversion results
module result_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge ref_clk) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// *** frame_ctrl.sv ***
// Serial frame, command and chained result logic of the converter
// Functional notes
// - In auto or fixed mode, chip select falling edge samples the selected channel and starts a conversion.
// - First 16 serial clock cycles carry the command for the next conversion.
// - Serial data out stays low while the command is shifting in.
// - Finished result loads 12 bits high plus four zero bits low.
// - Sixteenth falling edge drives the result MSB onto serial data out.
// - Later falling edges shift the chain input in and the next bit out.
// - Pass-through shifting is always on; no mode bit needed.
// - Chip select rising releases serial data out to high impedance.
// - After power-up the device idles and converts nothing until a command.
// - Configuration holds defaults at power-up until the host sets it.
// - All-zero command keeps the last mode and settings.
// - All-zero command during configuration access keeps settings, returns to idle.
// - A command acts only after its last bit on the sixteenth edge.
// - Chip select rising early enters invalid state until a proper command.
// - Invalid state returns meaningless data on reads.
// - Invalid state keeps limit flag tracking the previously selected channel.
// - Serial transfers are captured and launched on serial clock falling edges.
// - Configuration written in a frame applies at next chip select fall.
module frame_ctrl (
	input  wire logic                           ref_clk,
	input  wire logic                           reset_n,
	input  wire logic                           cs_n_pin,
	input  wire logic                           sclk_pin,
	input  wire logic                           sdi_pin,
	input  wire logic                           chain_in_pin,
	output logic                                sdo_out,
	output logic                                sdo_oe,
	output logic                                sample_strobe,
	output logic [frame_pkg::CHAN_BITS-1:0]     sample_channel,
	input  wire logic [frame_pkg::RESULT_BITS-1:0] conv_result,
	output logic [frame_pkg::CHAN_BITS-1:0]     limit_channel,
	output logic [frame_pkg::CMD_BITS-1:0]      config_word,
	output logic                                config_strobe,
	output logic [frame_pkg::FIFO_WIDTH-1:0]    result_data,
	output logic                                result_valid,
	input  wire logic                           result_ready,
	output logic                                result_overrun,
	output logic [5:0]                          mode_state
);
	// Pin synchronisers
	logic [1:0] cs_sync;
	logic [1:0] sclk_sync;
	logic [1:0] sdi_sync;
	logic [1:0] chain_sync;
	logic       cs_n;
	logic       cs_prev;
	logic       sclk_prev;
	logic       cs_fall;
	logic       cs_rise;
	logic       sclk_fall;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_sync    <= 2'h3;
			sclk_sync  <= 2'h0;
			sdi_sync   <= 2'h0;
			chain_sync <= 2'h0;
		end else begin
			cs_sync    <= {cs_sync[0], cs_n_pin};
			sclk_sync  <= {sclk_sync[0], sclk_pin};
			sdi_sync   <= {sdi_sync[0], sdi_pin};
			chain_sync <= {chain_sync[0], chain_in_pin};
		end
	end

	assign cs_n = cs_sync[1];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_prev   <= 1'b1;
			sclk_prev <= 1'b0;
		end else begin
			cs_prev   <= cs_n;
			sclk_prev <= sclk_sync[1];
		end
	end

	assign cs_fall   = cs_prev && !cs_n;
	assign cs_rise   = !cs_prev && cs_n;
	assign sclk_fall = sclk_prev && !sclk_sync[1] && !cs_n;

	function automatic logic is_hold(input logic [15:0] w);
		is_hold = (w == frame_pkg::CMD_HOLD);
	endfunction

	// Edge count and command shift
	logic [frame_pkg::CNT_BITS-1:0] edge_cnt;
	logic [frame_pkg::CMD_BITS-1:0] cmd_shift;
	logic                           cmd_done;
	logic                           cmd_fresh;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			edge_cnt  <= '0;
			cmd_shift <= '0;
		end else if (cs_fall) begin
			edge_cnt  <= '0;
		end else if (sclk_fall) begin
			if (edge_cnt != frame_pkg::CNT_MAX)
				edge_cnt <= edge_cnt + 1'b1;
			if (edge_cnt < frame_pkg::CMD_LAST_EDGE)
				cmd_shift <= {cmd_shift[14:0], sdi_sync[1]};
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			cmd_fresh <= 1'b0;
		else
			cmd_fresh <= sclk_fall && (edge_cnt == frame_pkg::CMD_LAST_EDGE - 7'h01);
	end

	// One-cycle pulse once the sixteenth bit is in, so short frames never act
	assign cmd_done = cmd_fresh && (edge_cnt == frame_pkg::CMD_LAST_EDGE);

	// Mode machine, command applied after its sixteenth edge, pending config at next frame start
	frame_pkg::mode_t mode;
	frame_pkg::mode_t next_mode;
	frame_pkg::mode_t prev_mode;
	logic [frame_pkg::CHAN_BITS-1:0] fixed_chan;
	logic [frame_pkg::CHAN_BITS-1:0] next_fixed_chan;
	logic [frame_pkg::CHAN_BITS-1:0] cur_chan;
	logic                            auto_restart;
	logic                            config_pending;
	logic                            config_access;

	always_comb begin
		next_mode       = mode;
		next_fixed_chan = fixed_chan;
		case (mode)
			frame_pkg::MODE_IDLE, frame_pkg::MODE_LIGHT, frame_pkg::MODE_DEEP,
			frame_pkg::MODE_AUTO, frame_pkg::MODE_FIXED, frame_pkg::MODE_INVALID: begin
				if (cmd_done) begin
					if (is_hold(cmd_shift)) begin
						if (mode == frame_pkg::MODE_INVALID)
							next_mode = frame_pkg::MODE_INVALID;
						else
							next_mode = mode;
					end else if (cmd_shift[15:8] == frame_pkg::CMD_LIGHT) begin
						next_mode = frame_pkg::MODE_LIGHT;
					end else if (cmd_shift[15:8] == frame_pkg::CMD_DEEP) begin
						next_mode = frame_pkg::MODE_DEEP;
					end else if (cmd_shift[15:8] == frame_pkg::CMD_AUTO) begin
						next_mode = frame_pkg::MODE_AUTO;
					end else if (cmd_shift[15:13] == frame_pkg::CMD_FIXED_HI) begin
						next_mode       = frame_pkg::MODE_FIXED;
						next_fixed_chan = cmd_shift[12:10];
					end else if (!cmd_shift[15]) begin
						next_mode = (mode == frame_pkg::MODE_INVALID) ? prev_mode : mode;
					end
				end
			end
			default: next_mode = frame_pkg::MODE_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode           <= frame_pkg::MODE_IDLE;
			prev_mode      <= frame_pkg::MODE_IDLE;
			fixed_chan     <= frame_pkg::CHAN_RESET;
			auto_restart   <= 1'b0;
			config_pending <= 1'b0;
			config_access  <= 1'b0;
			config_word    <= frame_pkg::CMD_HOLD;
			config_strobe  <= 1'b0;
		end else begin
			config_strobe <= 1'b0;
			if (cs_rise && edge_cnt < frame_pkg::CMD_LAST_EDGE && edge_cnt != '0) begin
				if (mode != frame_pkg::MODE_INVALID)
					prev_mode <= mode;
				mode          <= frame_pkg::MODE_INVALID;
				config_access <= 1'b0;
			end else if (cmd_done) begin
				// Hold command keeps mode; after a config access it falls back to idle
				if (is_hold(cmd_shift) && config_access)
					mode <= frame_pkg::MODE_IDLE;
				else
					mode <= next_mode;
				fixed_chan     <= next_fixed_chan;
				auto_restart   <= (cmd_shift[15:8] == frame_pkg::CMD_AUTO);
				config_access  <= !cmd_shift[15] && !is_hold(cmd_shift);
				if (!cmd_shift[15] && !is_hold(cmd_shift)) begin
					config_word    <= cmd_shift;
					config_pending <= 1'b1;
				end
			end else if (cs_fall && config_pending) begin
				config_strobe  <= 1'b1;
				config_pending <= 1'b0;
			end
		end
	end

	// Channel sequencing and conversion start
	logic [7:0] conv_cnt;
	logic       converting;
	logic       conv_done;
	logic       active;
	logic [frame_pkg::CHAN_BITS-1:0] limit_chan;
	logic [frame_pkg::CHAN_BITS-1:0] next_chan;

	assign active = (mode == frame_pkg::MODE_AUTO) || (mode == frame_pkg::MODE_FIXED);
	// Channel converted in the frame that starts now
	assign next_chan = (mode == frame_pkg::MODE_FIXED) ? fixed_chan :
		(auto_restart ? frame_pkg::CHAN_RESET : cur_chan + 1'b1);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur_chan   <= frame_pkg::CHAN_RESET;
			limit_chan <= frame_pkg::CHAN_RESET;
			converting <= 1'b0;
			conv_cnt   <= '0;
			conv_done  <= 1'b0;
		end else begin
			conv_done <= 1'b0;
			if (cs_fall && active) begin
				converting <= 1'b1;
				conv_cnt   <= frame_pkg::CONV_COUNT;
				cur_chan   <= next_chan;
			end else if (converting) begin
				if (conv_cnt == 8'h01) begin
					converting <= 1'b0;
					conv_done  <= 1'b1;
				end
				conv_cnt <= conv_cnt - 1'b1;
			end
			if (mode != frame_pkg::MODE_INVALID)
				limit_chan <= cur_chan;
		end
	end

	assign sample_strobe  = cs_fall && active;
	assign sample_channel = next_chan;
	assign limit_channel  = limit_chan;

	// Output shift register
	logic [frame_pkg::SHIFT_BITS-1:0] out_shift;
	logic [frame_pkg::SHIFT_BITS-1:0] garbage;
	logic                             sdo_bit;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			garbage <= frame_pkg::GARBAGE_SEED;
		end else begin
			garbage <= {garbage[14:0], garbage[15] ^ garbage[13] ^ garbage[12] ^ garbage[10]};
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_shift <= '0;
			sdo_bit   <= 1'b0;
		end else if (cs_fall) begin
			out_shift <= '0;
			sdo_bit   <= 1'b0;
		end else if (conv_done) begin
			out_shift <= {conv_result, 4'h0};
		end else if (sclk_fall) begin
			if (edge_cnt == frame_pkg::CMD_LAST_EDGE - 7'h01) begin
				if (mode == frame_pkg::MODE_INVALID)
					sdo_bit <= garbage[15];
				else
					sdo_bit <= out_shift[15];
			end else if (edge_cnt >= frame_pkg::CMD_LAST_EDGE) begin
				out_shift <= {out_shift[14:0], chain_sync[1]};
				sdo_bit   <= (mode == frame_pkg::MODE_INVALID) ? garbage[15] : out_shift[14];
			end else begin
				sdo_bit <= 1'b0;
			end
		end
	end

	assign sdo_out = sdo_bit;
	assign sdo_oe  = !cs_n;

	// Result capture into the FIFO
	logic fifo_in_ready;
	logic overrun;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			overrun <= 1'b0;
		else if (conv_done && !fifo_in_ready)
			overrun <= 1'b1;
		else if (cs_fall)
			overrun <= 1'b0;
	end

	result_fifo #(
		.WIDTH(frame_pkg::FIFO_WIDTH),
		.DEPTH(frame_pkg::FIFO_DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.reset_n  (reset_n),
		.in_data  (conv_result),
		.in_valid (conv_done),
		.in_ready (fifo_in_ready),
		.out_data (result_data),
		.out_valid(result_valid),
		.out_ready(result_ready)
	);

	assign result_overrun = overrun;
	assign mode_state     = mode;
endmodule

// *** frame_check_properties.sv ***
// Port assertions for the serial frame logic
module frame_check (
	input wire logic                          ref_clk,
	input wire logic                          reset_n,
	input wire logic                          cs_n_pin,
	input wire logic                          sclk_pin,
	input wire logic                          sdo_out,
	input wire logic                          sdo_oe,
	input wire logic                          sample_strobe,
	input wire logic [frame_pkg::CHAN_BITS-1:0] limit_channel,
	input wire logic                          config_strobe,
	input wire logic [5:0]                    mode_state
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	a_out_released: assert property (cs_n_pin [*4] |-> !sdo_oe)
		else $error("sdo enabled while deselected");
	a_out_driven: assert property ((!cs_n_pin) [*4] |-> sdo_oe)
		else $error("sdo not enabled while selected");
	a_cmd_low: assert property ($fell(cs_n_pin) |-> ##4 (!sdo_out) [*8])
		else $error("sdo not low during command");
	a_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
		else $error("sample strobe longer than one cycle");
	a_strobe_mode: assert property (sample_strobe |-> mode_state inside {frame_pkg::MODE_AUTO, frame_pkg::MODE_FIXED})
		else $error("sample outside a converting mode");
	a_mode_steady: assert property ($fell(cs_n_pin) |=> $stable(mode_state) [*8])
		else $error("mode changed before command complete");
	a_cfg_pulse: assert property (config_strobe |-> !cs_n_pin ##1 !config_strobe)
		else $error("config strobe outside frame start");
	a_limit_frozen: assert property (mode_state == frame_pkg::MODE_INVALID && $past(mode_state) == frame_pkg::MODE_INVALID |-> $stable(limit_channel))
		else $error("limit channel moved in invalid state");
	a_sdo_quiet: assert property ((sclk_pin && !cs_n_pin) [*8] |-> $stable(sdo_out))
		else $error("sdo changed without a clock fall");
endmodule

bind frame_ctrl frame_check i_check (.ref_clk, .reset_n, .cs_n_pin, .sclk_pin, .sdo_out, .sdo_oe,
	.sample_strobe, .limit_channel, .config_strobe, .mode_state);

// *** host_model.sv ***
// Host controller model driving one serial frame at a time
module host_model (
	input  wire logic ref_clk,
	input  wire logic sdo_out,
	input  wire logic sdo_oe,
	output logic      cs_n_pin,
	output logic      sclk_pin,
	output logic      sdi_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cs_n_pin = 1'b1;
		sclk_pin = 1'b1;
		sdi_pin  = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Fewer than 16 edges aborts the frame on purpose
	task automatic frame(input logic [15:0] cmd, input int n, output logic [31:0] got);
		got = '0;
		wait_clk(1);
		cs_n_pin = 1'b0;
		wait_clk(12);
		for (int e = 1; e <= n; e++) begin
			sdi_pin = (e <= 16) ? cmd[16 - e] : ~sdi_pin;
			wait_clk(4);
			if (e > 16)
				got = {got[30:0], sdo_oe ? sdo_out : ~got[0]};
			sclk_pin = 1'b0;
			wait_clk(4);
			sclk_pin = 1'b1;
		end
		wait_clk(4);
		cs_n_pin = 1'b1;
		sdi_pin = ~sdi_pin;
		wait_clk(8);
	endtask
endmodule

// *** adc_serial_frame_daisy_mode_ctrl_bench.sv ***
// Self-checking bench for the serial frame logic
module adc_serial_frame_daisy_mode_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [15:0] cmd; int n; logic chain; logic [5:0] mode; logic [31:0] word; logic chk;} row_t;
	logic        ref_clk = 1'b0;
	logic        reset_n;
	logic        chain_in_pin;
	logic [11:0] conv_result;
	logic        result_ready;
	logic        cs_n_pin;
	logic        sclk_pin;
	logic        sdi_pin;
	logic        sdo_out;
	logic        sdo_oe;
	logic [11:0] result_data;
	logic        result_valid;
	logic [2:0]  limit_channel;
	logic [2:0]  sample_channel;
	logic        result_overrun;
	logic [15:0] config_word;
	logic [5:0]  mode_state;
	logic [31:0] got;
	int          n_fail = 0;
	int          checks = 0;
	// Mode 0 means the mode is not compared
	row_t rows [9] = '{
		'{16'hA000, 32, 1'b0, frame_pkg::MODE_AUTO, 32'h0, 1'b0},
		'{16'h0000, 32, 1'b0, frame_pkg::MODE_AUTO, 32'hABC0, 1'b1},
		'{16'h0000, 48, 1'b1, frame_pkg::MODE_AUTO, 32'hABC0FFFF, 1'b1},
		'{16'hCC00, 32, 1'b0, frame_pkg::MODE_FIXED, 32'hABC0, 1'b1},
		'{16'h8200, 32, 1'b0, frame_pkg::MODE_LIGHT, 32'hABC0, 1'b1},
		'{16'h0000, 32, 1'b0, frame_pkg::MODE_LIGHT, 32'h0, 1'b0},
		'{16'h8300, 32, 1'b0, frame_pkg::MODE_DEEP, 32'h0, 1'b0},
		'{16'h1234, 32, 1'b0, 6'h00, 32'h0, 1'b0},
		'{16'h0000, 32, 1'b0, frame_pkg::MODE_IDLE, 32'h0, 1'b0}
	};

	always #25 ref_clk = ~ref_clk;

	frame_ctrl i_dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
		.chain_in_pin(chain_in_pin), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sample_strobe(),
		.sample_channel(sample_channel),
		.conv_result(conv_result), .limit_channel(limit_channel), .config_word(config_word), .config_strobe(),
		.result_data(result_data), .result_valid(result_valid), .result_ready(result_ready),
		.result_overrun(result_overrun), .mode_state(mode_state)
	);
	host_model i_host (
		.ref_clk(ref_clk), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
		.cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin)
	);

	task automatic check_val(input logic [31:0] act, input logic [31:0] exp);
		checks++;
		if (act !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, act, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#1000000;
		n_fail++;
		print_verdict();
	end

	initial begin
		reset_n = 1'b0;
		chain_in_pin = 1'b0;
		conv_result = 12'hABC;
		result_ready = 1'b0;
		repeat (3) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		check_val(32'(mode_state), 32'(frame_pkg::MODE_IDLE));
		check_val(32'(sdo_oe), 32'h0);
		foreach (rows[i]) begin
			chain_in_pin = rows[i].chain;
			i_host.frame(rows[i].cmd, rows[i].n, got);
			if (rows[i].chk)
				check_val(got, rows[i].word);
			if (rows[i].mode != 6'h00)
				check_val(32'(mode_state), 32'(rows[i].mode));
		end
		check_val(32'(sdo_oe), 32'h0);
		check_val(32'(config_word), 32'h1234);
		check_val(32'(result_valid), 32'h1);
		check_val(32'(result_data), 32'hABC);
		result_ready = 1'b1;
		repeat (12) @(negedge ref_clk);
		check_val(32'(result_valid), 32'h0);
		check_val(32'(result_overrun), 32'h0);
		i_host.frame(16'hCC00, 32, got);
		check_val(32'(sample_channel), 32'h3);
		i_host.frame(16'hA000, 8, got);
		check_val(32'(mode_state), 32'(frame_pkg::MODE_INVALID));
		check_val(32'(limit_channel), 32'h3);
		i_host.frame(16'h0000, 32, got);
		check_val(32'(mode_state), 32'(frame_pkg::MODE_INVALID));
		i_host.frame(16'hA000, 32, got);
		check_val(32'(mode_state), 32'(frame_pkg::MODE_AUTO));
		reset_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		check_val(32'(mode_state), 32'(frame_pkg::MODE_IDLE));
		check_val(32'(config_word), 32'(frame_pkg::CMD_HOLD));
		i_host.frame(16'hA000, 16, got);
		check_val(32'(mode_state), 32'(frame_pkg::MODE_AUTO));
		print_verdict();
	end
endmodule
